/* inc/dag_if.sv */
interface dag_if;
	logic        ld;
	logic [1:0]  ld_kind;
	logic [1:0]  ld_idx;
	logic [13:0] ld_data;
	logic        step;
	logic [1:0]  isel;
	logic [1:0]  msel;
	logic        rev;
	logic [13:0] addr;
	modport ctl (output ld, ld_kind, ld_idx, ld_data, step, isel, msel, rev, input addr);
	modport gen (input ld, ld_kind, ld_idx, ld_data, step, isel, msel, rev, output addr);
endinterface : dag_if

/* inc/dsp_pkg.sv */
package dsp_pkg;
	localparam int DW = 16;
	localparam int AW = 14;
	// mode status word bit positions
	localparam int MS_BANK  = 0;
	localparam int MS_REV   = 1;
	localparam int MS_OVH   = 2;
	localparam int MS_CLAMP = 3;
	localparam int MS_PLACE = 4;
	localparam int MS_TIMER = 5;
	localparam int MS_GRANT = 6;
	localparam logic [6:0] MS_RST = 7'h00;
	// arithmetic status word bit positions
	localparam int FL_ZERO  = 0;
	localparam int FL_NEG   = 1;
	localparam int FL_OVF   = 2;
	localparam int FL_CARRY = 3;
	localparam int FL_ABSS  = 4;
	localparam int FL_MOVF  = 6;
	localparam int FL_SHS   = 7;
	localparam logic [7:0] FL_RST = 8'h00;
	// opcode prefixes
	localparam logic [7:0] OP_MODE   = 8'h0c;
	localparam logic [7:0] OP_MODIFY = 8'h05;
	localparam logic [7:0] OP_SHPM   = 8'h11;
	localparam logic [2:0] OP_AMDM   = 3'h3;
	localparam logic [3:0] OP_AMPM   = 4'h5;
	localparam logic [6:0] OP_SHDM   = 7'h09;
	// instruction field positions
	localparam int AM_G = 20;
	localparam int AM_DIR = 19;
	localparam int AM_Z = 18;
	localparam int AM_FN = 13;
	localparam int SH_G = 16;
	localparam int SH_DIR = 15;
	localparam int SH_FN = 11;
	localparam int MD_G = 4;
	localparam int F_YOP = 11;
	localparam int F_XOP = 8;
	localparam int F_DREG = 4;
	localparam int F_ISEL = 2;
	localparam int F_MSEL = 0;
	// mode-control field positions and codes
	localparam int MF_TIMER = 12;
	localparam int MF_PLACE = 10;
	localparam int MF_CLAMP = 8;
	localparam int MF_OVH = 6;
	localparam int MF_REV = 4;
	localparam int MF_BANK = 2;
	localparam int MF_GRANT = 0;
	localparam logic [1:0] MF_ENA = 2'h3;
	localparam logic [1:0] MF_DIS = 2'h2;
	// compute function codes
	localparam logic [4:0] FN_ADD = 5'h13;
	localparam logic [4:0] FN_SUB = 5'h17;
	localparam logic [4:0] FN_ABSV = 5'h1f;
	localparam logic [4:0] FN_PASSY = 5'h10;
	localparam logic [4:0] FN_AND = 5'h1c;
	localparam logic [4:0] FN_MUL = 5'h01;
	localparam logic [4:0] FN_MAC = 5'h02;
	localparam logic [4:0] FN_MSUB = 5'h03;
	localparam logic [3:0] SH_NORM = 4'hc;
	localparam logic [3:0] SH_LSL = 4'h0;
	// data register indices, then load kinds, timer reload and saturation values
	localparam logic [3:0] D_XA0 = 4'h0;
	localparam logic [3:0] D_XM0 = 4'h2;
	localparam logic [3:0] D_YA0 = 4'h4;
	localparam logic [3:0] D_YM0 = 4'h6;
	localparam logic [3:0] D_SHIN = 4'h8;
	localparam logic [3:0] D_SHEXP = 4'h9;
	localparam logic [3:0] D_ALUR = 4'ha;
	localparam logic [3:0] D_MAC0 = 4'hb;
	localparam logic [3:0] D_MAC1 = 4'hc;
	localparam logic [3:0] D_MAC2 = 4'hd;
	localparam logic [3:0] D_SHLO = 4'he;
	localparam logic [3:0] D_SHHI = 4'hf;
	localparam logic [1:0] LD_IDX = 2'h0;
	localparam logic [1:0] LD_MOD = 2'h1;
	localparam logic [1:0] LD_LEN = 2'h2;
	localparam logic [15:0] TMR_RELOAD = 16'h00ff;
	localparam logic [15:0] SAT_POS = 16'h7fff;
	localparam logic [15:0] SAT_NEG = 16'h8000;
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_MEM = 2'b10} state_e;
endpackage : dsp_pkg

/* src/addr_gen.sv */
module addr_gen #(
	parameter bit CAN_REV = 1'b0
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	dag_if.gen       port_io
);
	logic [13:0] idx_r [4];
	logic [13:0] mod_r [4];
	logic [13:0] len_r [4];
	logic [13:0] base_r [4];
	logic [13:0] cur, stp, len, base, sum, end_a, wrapped, rev_addr;

	always_comb begin
		cur = idx_r[port_io.isel];
		stp = mod_r[port_io.msel];
		len = len_r[port_io.isel];
		base = base_r[port_io.isel];
		sum = cur + stp;
		end_a = base + len;
		wrapped = sum;
		if (len != 14'h0) begin
			if (!stp[13] && sum >= end_a) wrapped = sum - len;
			else if (stp[13] && sum < base) wrapped = sum + len;
		end
		for (int b = 0; b < 14; b++) rev_addr[b] = cur[13 - b];
	end

	assign port_io.addr = (CAN_REV && port_io.rev) ? rev_addr : cur;

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			for (int k = 0; k < 4; k++) begin
				idx_r[k] <= 14'h0;
				mod_r[k] <= 14'h0;
				len_r[k] <= 14'h0;
				base_r[k] <= 14'h0;
			end
		end else begin
			// index and modify from one generator
			if (port_io.step) idx_r[port_io.isel] <= wrapped;
			if (port_io.ld) begin
				case (port_io.ld_kind)
					dsp_pkg::LD_IDX: begin
						idx_r[port_io.ld_idx] <= port_io.ld_data;
						base_r[port_io.ld_idx] <= port_io.ld_data;
					end
					dsp_pkg::LD_MOD: mod_r[port_io.ld_idx] <= port_io.ld_data;
					dsp_pkg::LD_LEN: len_r[port_io.ld_idx] <= port_io.ld_data;
					default: ;
				endcase
			end
		end
	end

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	AST_LINEAR_STEP: assert property (port_io.step && len == 14'h0 && !port_io.ld
		|=> idx_r[$past(port_io.isel)] == $past(sum)) else $error("linear step wrong");
	AST_WRAP_INSIDE: assert property (port_io.step && len != 14'h0 && !port_io.ld && cur >= base
		&& cur < end_a && end_a > base && base >= len && end_a + len > end_a
		&& (stp[13] ? (14'h0 - stp) <= len : stp <= len)
		|=> idx_r[$past(port_io.isel)] >= $past(base) && idx_r[$past(port_io.isel)] < $past(end_a))
		else $error("index left its buffer");
endmodule : addr_gen

/* src/dsp_mode_exec.sv */
module dsp_mode_exec (
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic [23:0] instr_i,
	input  wire logic        instr_valid_i,
	output logic             instr_ready_o,
	input  wire logic        stat_wr_i,
	input  wire logic        stat_sel_i,
	input  wire logic [15:0] dbus_i,
	input  wire logic        dag_ld_i,
	input  wire logic        dag_ld_gen_i,
	input  wire logic [1:0]  dag_ld_kind_i,
	input  wire logic [1:0]  dag_ld_idx_i,
	input  wire logic [13:0] dag_ld_data_i,
	output logic             mem_rd_o,
	output logic             mem_pm_o,
	output logic [13:0]      mem_addr_o,
	input  wire logic [15:0] mem_rdata_i,
	input  wire logic        bus_req_i,
	output logic             bus_grant_o,
	output logic [7:0]       arith_status_o,
	output logic [6:0]       mode_status_o,
	output logic             timer_tick_o,
	output logic [15:0]      result_o
);
	dsp_pkg::state_e state_r;
	logic [15:0] rf_r [2][16];
	logic [23:0] ir_r;
	logic [7:0]  arith_status_word_r, arith_status_word_nxt;
	logic [6:0]  mode_status_control_r, mode_status_control_nxt;
	logic [15:0] tmr_r;
	logic        tick_r, grant_r, req_f, rd_r, pm_r, bank;
	logic [13:0] addr_r;
	logic        is_nop, is_mode, is_mod, is_amdm, is_ampm, is_shdm, is_shpm;
	logic        needs_mem, use_g1, take;
	logic        ex_am, alu_op, mac_op, sh_norm, sh_lsl;
	logic [4:0]  fn;
	logic [15:0] x, y, ares, expo;
	logic [16:0] s17, uadd, usub;
	logic        ovf_ev, cy, movf, hit;
	logic [4:0]  lz;
	logic signed [31:0] prod, placed;
	logic [39:0] macc, pext, acc;
	logic [31:0] sh32;

	dag_if g0 ();
	dag_if g1 ();

	pin_sync u_req_sync (
		.mclk_i  (mclk_i),
		.rst_b_i (rst_b_i),
		.pin_i   (bus_req_i),
		.level_o (req_f)
	);

	addr_gen #(.CAN_REV(1'b1)) u_gen0 (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .port_io(g0.gen));
	addr_gen #(.CAN_REV(1'b0)) u_gen1 (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .port_io(g1.gen));

	assign bank = mode_status_control_r[dsp_pkg::MS_BANK];

	assign is_nop = (instr_i == 24'h0);
	assign is_mode = (instr_i[23:16] == dsp_pkg::OP_MODE);
	assign is_mod = (instr_i[23:16] == dsp_pkg::OP_MODIFY);
	assign is_amdm = (instr_i[23:21] == dsp_pkg::OP_AMDM) && !instr_i[dsp_pkg::AM_DIR];
	assign is_ampm = (instr_i[23:20] == dsp_pkg::OP_AMPM) && !instr_i[dsp_pkg::AM_DIR];
	assign is_shdm = (instr_i[23:17] == dsp_pkg::OP_SHDM) && !instr_i[dsp_pkg::SH_DIR];
	assign is_shpm = (instr_i[23:16] == dsp_pkg::OP_SHPM) && !instr_i[dsp_pkg::SH_DIR];
	assign needs_mem = is_amdm | is_ampm | is_shdm | is_shpm;
	// generator choice; program memory uses upper four only
	assign use_g1 = is_ampm | is_shpm | (is_amdm & instr_i[dsp_pkg::AM_G])
		| (is_shdm & instr_i[dsp_pkg::SH_G]) | (is_mod & instr_i[dsp_pkg::MD_G]);

	// grant stalls all unless run mode; memory forms wait for release
	assign instr_ready_o = (state_r == dsp_pkg::ST_IDLE)
		&& (!grant_r || (mode_status_control_r[dsp_pkg::MS_GRANT] && !needs_mem));
	// unknown or all-zero words are taken and do nothing
	assign take = instr_valid_i & instr_ready_o;

	// modify steps the index with no memory cycle; post-modify on issue
	assign g0.step = take & (needs_mem | is_mod) & ~use_g1;
	assign g1.step = take & (needs_mem | is_mod) & use_g1;
	assign g0.isel = instr_i[dsp_pkg::F_ISEL +: 2];
	assign g1.isel = instr_i[dsp_pkg::F_ISEL +: 2];
	assign g0.msel = instr_i[dsp_pkg::F_MSEL +: 2];
	assign g1.msel = instr_i[dsp_pkg::F_MSEL +: 2];
	// only the first generator can mirror
	assign g0.rev = mode_status_control_r[dsp_pkg::MS_REV];
	assign g1.rev = 1'b0;
	assign g0.ld = dag_ld_i & ~dag_ld_gen_i;
	assign g1.ld = dag_ld_i & dag_ld_gen_i;
	assign g0.ld_kind = dag_ld_kind_i;
	assign g1.ld_kind = dag_ld_kind_i;
	assign g0.ld_idx = dag_ld_idx_i;
	assign g1.ld_idx = dag_ld_idx_i;
	assign g0.ld_data = dag_ld_data_i;
	assign g1.ld_data = dag_ld_data_i;

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) state_r <= dsp_pkg::ST_IDLE;
		else if (state_r == dsp_pkg::ST_MEM) state_r <= dsp_pkg::ST_IDLE;
		else if (take && needs_mem) state_r <= dsp_pkg::ST_MEM;
	end

	// address registered at issue, data returns in the execute cycle
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			ir_r <= 24'h0;
			rd_r <= 1'b0;
			pm_r <= 1'b0;
			addr_r <= 14'h0;
		end else begin
			rd_r <= take & needs_mem;
			if (take && needs_mem) begin
				ir_r <= instr_i;
				pm_r <= is_ampm | is_shpm;
				addr_r <= use_g1 ? g1.addr : g0.addr;
			end
		end
	end

	// grant only between instructions; a held memory cycle finishes first
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) grant_r <= 1'b0;
		else if (!req_f) grant_r <= 1'b0;
		else if (state_r == dsp_pkg::ST_IDLE && !(take && needs_mem)) grant_r <= 1'b1;
	end

	assign ex_am = (ir_r[23:21] == dsp_pkg::OP_AMDM) || (ir_r[23:20] == dsp_pkg::OP_AMPM);
	assign fn = ir_r[dsp_pkg::AM_FN +: 5];
	// unconditional compute; undecoded ALU codes pass x to the result, undecoded multiplier codes store the product
	assign alu_op = rd_r & ex_am & fn[4];
	assign mac_op = rd_r & ex_am & ~fn[4] & (fn != 5'h00);
	assign sh_norm = rd_r & ~ex_am & (ir_r[dsp_pkg::SH_FN +: 4] == dsp_pkg::SH_NORM);
	assign sh_lsl = rd_r & ~ex_am & (ir_r[dsp_pkg::SH_FN +: 4] == dsp_pkg::SH_LSL);

	function automatic logic [3:0] xsel(input logic [2:0] xop, input logic [3:0] b);
		logic [3:0] r;
		r = b;
		case (xop)
			3'h0: r = b;
			3'h1: r = b | 4'h1;
			3'h2: r = dsp_pkg::D_ALUR;
			3'h3: r = dsp_pkg::D_MAC0;
			3'h4: r = dsp_pkg::D_MAC1;
			3'h5: r = dsp_pkg::D_MAC2;
			3'h6: r = dsp_pkg::D_SHLO;
			default: r = dsp_pkg::D_SHHI;
		endcase
		return r;
	endfunction : xsel

	// operands come from the registers as they stood at cycle start
	always_comb begin
		x = rf_r[bank][xsel(ir_r[dsp_pkg::F_XOP +: 3], !ex_am ? dsp_pkg::D_SHIN
			: (fn[4] ? dsp_pkg::D_XA0 : dsp_pkg::D_XM0))];
		y = ir_r[dsp_pkg::F_YOP + 1] ? 16'h0
			: rf_r[bank][(fn[4] ? dsp_pkg::D_YA0 : dsp_pkg::D_YM0) | {3'h0, ir_r[dsp_pkg::F_YOP]}];
		uadd = {1'b0, x} + {1'b0, y};
		usub = {1'b0, x} + {1'b0, ~y} + 17'h1;
		cy = 1'b0;
		case (fn)
			dsp_pkg::FN_ADD: begin
				s17 = {x[15], x} + {y[15], y};
				cy = uadd[16];
			end
			dsp_pkg::FN_SUB: begin
				s17 = {x[15], x} - {y[15], y};
				cy = usub[16];
			end
			dsp_pkg::FN_ABSV: s17 = x[15] ? 17'h0 - {x[15], x} : {x[15], x};
			dsp_pkg::FN_PASSY: s17 = {y[15], y};
			dsp_pkg::FN_AND: s17 = {x[15] & y[15], x & y};
			default: s17 = {x[15], x};
		endcase
		ovf_ev = s17[16] ^ s17[15];
		if (ovf_ev && mode_status_control_r[dsp_pkg::MS_CLAMP]) ares = s17[16] ? dsp_pkg::SAT_NEG : dsp_pkg::SAT_POS;
		else ares = s17[15:0];
		prod = $signed(x) * $signed(y);
		// fractional placement shifts left once, integer placement does not
		placed = mode_status_control_r[dsp_pkg::MS_PLACE] ? prod : (prod <<< 1);
		pext = {{8{placed[31]}}, placed};
		macc = {rf_r[bank][dsp_pkg::D_MAC2][7:0], rf_r[bank][dsp_pkg::D_MAC1], rf_r[bank][dsp_pkg::D_MAC0]};
		if (fn == dsp_pkg::FN_MAC) acc = macc + pext;
		else if (fn == dsp_pkg::FN_MSUB) acc = macc - pext;
		else acc = pext;
		// upper guard bits must all match the sign of bit 31
		movf = !((&acc[39:31]) || !(|acc[39:31]));
		lz = 5'h0;
		hit = 1'b0;
		for (int i = 14; i >= 0; i--) begin
			if (x[i] != x[15]) hit = 1'b1;
			else if (!hit) lz = lz + 5'h1;
		end
		expo = 16'h0 - {11'h0, lz};
		sh32 = {16'h0, x} << rf_r[bank][dsp_pkg::D_SHEXP][3:0];
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			for (int b = 0; b < 2; b++)
				for (int r = 0; r < 16; r++) rf_r[b][r] <= 16'h0;
		end else if (rd_r) begin
			if (alu_op && !ir_r[dsp_pkg::AM_Z]) rf_r[bank][dsp_pkg::D_ALUR] <= ares;
			if (mac_op && !ir_r[dsp_pkg::AM_Z]) begin
				rf_r[bank][dsp_pkg::D_MAC0] <= acc[15:0];
				rf_r[bank][dsp_pkg::D_MAC1] <= acc[31:16];
				rf_r[bank][dsp_pkg::D_MAC2] <= {{8{acc[39]}}, acc[39:32]};
			end
			if (sh_norm) rf_r[bank][dsp_pkg::D_SHEXP] <= expo;
			if (sh_lsl) begin
				rf_r[bank][dsp_pkg::D_SHLO] <= sh32[15:0];
				rf_r[bank][dsp_pkg::D_SHHI] <= sh32[31:16];
			end
			// memory word written whole, low bit aligned
			rf_r[bank][ir_r[dsp_pkg::F_DREG +: 4]] <= mem_rdata_i;
		end
	end

	always_comb begin
		arith_status_word_nxt = arith_status_word_r;
		if (stat_wr_i && !stat_sel_i) arith_status_word_nxt = dbus_i[7:0];
		if (alu_op) begin
			arith_status_word_nxt[dsp_pkg::FL_ZERO] = (ares == 16'h0);
			arith_status_word_nxt[dsp_pkg::FL_NEG] = ares[15];
			arith_status_word_nxt[dsp_pkg::FL_CARRY] = cy;
			// held flag; a bus write of zero loses to a new overflow
			arith_status_word_nxt[dsp_pkg::FL_OVF] = ovf_ev | (mode_status_control_r[dsp_pkg::MS_OVH] & arith_status_word_nxt[dsp_pkg::FL_OVF]);
			// only absolute value and a bus write of the arithmetic word touch this flag
			if (fn == dsp_pkg::FN_ABSV) arith_status_word_nxt[dsp_pkg::FL_ABSS] = x[15];
		end
		if (mac_op) arith_status_word_nxt[dsp_pkg::FL_MOVF] = movf;
		// only exponent detect and a bus write of the arithmetic word touch the shifter sign
		if (sh_norm) arith_status_word_nxt[dsp_pkg::FL_SHS] = x[15];
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) arith_status_word_r <= dsp_pkg::FL_RST;
		else arith_status_word_r <= arith_status_word_nxt;
	end

	function automatic logic apply(input logic cur, input logic [1:0] f);
		return (f == dsp_pkg::MF_ENA) ? 1'b1 : ((f == dsp_pkg::MF_DIS) ? 1'b0 : cur);
	endfunction : apply

	always_comb begin
		mode_status_control_nxt = mode_status_control_r;
		if (stat_wr_i && stat_sel_i) mode_status_control_nxt = dbus_i[6:0];
		if (take && is_mode) begin
			// every field applied in the same cycle; bit layout
			mode_status_control_nxt[dsp_pkg::MS_BANK] = apply(mode_status_control_nxt[dsp_pkg::MS_BANK], instr_i[dsp_pkg::MF_BANK +: 2]);
			mode_status_control_nxt[dsp_pkg::MS_REV] = apply(mode_status_control_nxt[dsp_pkg::MS_REV], instr_i[dsp_pkg::MF_REV +: 2]);
			mode_status_control_nxt[dsp_pkg::MS_OVH] = apply(mode_status_control_nxt[dsp_pkg::MS_OVH], instr_i[dsp_pkg::MF_OVH +: 2]);
			mode_status_control_nxt[dsp_pkg::MS_CLAMP] = apply(mode_status_control_nxt[dsp_pkg::MS_CLAMP], instr_i[dsp_pkg::MF_CLAMP +: 2]);
			mode_status_control_nxt[dsp_pkg::MS_PLACE] = apply(mode_status_control_nxt[dsp_pkg::MS_PLACE], instr_i[dsp_pkg::MF_PLACE +: 2]);
			mode_status_control_nxt[dsp_pkg::MS_TIMER] = apply(mode_status_control_nxt[dsp_pkg::MS_TIMER], instr_i[dsp_pkg::MF_TIMER +: 2]);
			mode_status_control_nxt[dsp_pkg::MS_GRANT] = apply(mode_status_control_nxt[dsp_pkg::MS_GRANT], instr_i[dsp_pkg::MF_GRANT +: 2]);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) mode_status_control_r <= dsp_pkg::MS_RST;
		else mode_status_control_r <= mode_status_control_nxt;
	end

	// down counter runs only while enabled
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			tmr_r <= dsp_pkg::TMR_RELOAD;
			tick_r <= 1'b0;
		end else begin
			tick_r <= mode_status_control_r[dsp_pkg::MS_TIMER] && (tmr_r == 16'h0);
			if (mode_status_control_r[dsp_pkg::MS_TIMER]) tmr_r <= (tmr_r == 16'h0) ? dsp_pkg::TMR_RELOAD : tmr_r - 16'h1;
		end
	end

	assign mem_rd_o = rd_r;
	assign mem_pm_o = pm_r;
	assign mem_addr_o = addr_r;
	assign bus_grant_o = grant_r;
	assign arith_status_o = arith_status_word_r;
	assign mode_status_o = mode_status_control_r;
	assign timer_tick_o = tick_r;
	assign result_o = rf_r[bank][dsp_pkg::D_ALUR];

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	AST_BANK_SET: assert property (take && is_mode && instr_i[dsp_pkg::MF_BANK +: 2] == dsp_pkg::MF_ENA
		|=> bank == 1'b1) else $error("bank select not set");
	AST_OVF_HELD: assert property (arith_status_word_r[dsp_pkg::FL_OVF] && mode_status_control_r[dsp_pkg::MS_OVH] && !stat_wr_i
		&& !(take && is_mode) |=> arith_status_word_r[dsp_pkg::FL_OVF]) else $error("held overflow dropped");
	AST_OVF_CLEAR_BUS: assert property ($fell(arith_status_word_r[dsp_pkg::FL_OVF]) && $past(mode_status_control_r[dsp_pkg::MS_OVH])
		|-> $past(stat_wr_i && !stat_sel_i)) else $error("held overflow cleared without bus write");
	AST_CLAMP: assert property (alu_op && ovf_ev && mode_status_control_r[dsp_pkg::MS_CLAMP] && !ir_r[dsp_pkg::AM_Z]
		|=> result_o == dsp_pkg::SAT_POS || result_o == dsp_pkg::SAT_NEG) else $error("no saturation");
	AST_TIMER_HALT: assert property (!mode_status_control_r[dsp_pkg::MS_TIMER] |=> $stable(tmr_r) && !tick_r)
		else $error("timer moved while halted");
	AST_GRANT_STALL: assert property (grant_r && !mode_status_control_r[dsp_pkg::MS_GRANT] |-> !instr_ready_o)
		else $error("executing during grant");
	AST_GRANT_MEM_WAIT: assert property (grant_r && needs_mem |-> !instr_ready_o)
		else $error("memory access during grant");
	AST_RESET_MODES: assert property ($rose(rst_b_i) |-> mode_status_o == 7'h00)
		else $error("modes not cleared by reset");
	AST_NOP_QUIET: assert property (take && is_nop && !stat_wr_i && !rd_r
		|=> $stable(arith_status_o) && $stable(mode_status_o) && state_r == dsp_pkg::ST_IDLE)
		else $error("nop changed state");
	AST_MEM_ONE_CYCLE: assert property (take && needs_mem |=> mem_rd_o && !instr_ready_o ##1 !mem_rd_o)
		else $error("memory read timing wrong");
	COV_MODE: cover property (take && is_mode);
	COV_READ: cover property (take && needs_mem ##1 alu_op);
	COV_GRANT_RUN: cover property (grant_r && mode_status_control_r[dsp_pkg::MS_GRANT] && take);
endmodule : dsp_mode_exec

/* src/pin_sync.sv */
module pin_sync (
	input  wire logic mclk_i,
	input  wire logic rst_b_i,
	input  wire logic pin_i,
	output logic      level_o
);
	logic [2:0] sh_r;
	logic       lvl_r;

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) sh_r <= 3'h0;
		else sh_r <= {sh_r[1:0], pin_i};
	end

	// a change counts once the second and third stages agree
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) lvl_r <= 1'b0;
		else if (sh_r[1] == sh_r[2]) lvl_r <= sh_r[2];
	end

	assign level_o = lvl_r;
endmodule : pin_sync

/* verification/dsp_mode_and_multifunction_exec_bench.sv */
module dsp_mode_and_multifunction_exec_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk_i = 1'b0, rst_b_i = 1'b0, vld = 1'b0, swr = 1'b0, ssel = 1'b0;
	logic        ld = 1'b0, lg = 1'b0, want = 1'b0, rdy, mrd, req, grant, tick, pm;
	logic [1:0]  lk = 2'h0, li = 2'h0;
	logic [13:0] ldd = 14'h0, maddr, b, a;
	logic [23:0] instr = 24'h0;
	logic [15:0] dbus = 16'h0, rdata, res, v;
	logic [7:0]  ast;
	logic [6:0]  mst;
	int          err_total = 0, comparisons = 0, cyc = 0;
	int          fp [7] = '{dsp_pkg::MF_BANK, dsp_pkg::MF_REV, dsp_pkg::MF_OVH, dsp_pkg::MF_CLAMP,
	             dsp_pkg::MF_PLACE, dsp_pkg::MF_TIMER, dsp_pkg::MF_GRANT};
	dsp_mode_exec dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .instr_i(instr), .instr_valid_i(vld),
		.instr_ready_o(rdy), .stat_wr_i(swr), .stat_sel_i(ssel), .dbus_i(dbus), .dag_ld_i(ld),
		.dag_ld_gen_i(lg), .dag_ld_kind_i(lk), .dag_ld_idx_i(li), .dag_ld_data_i(ldd),
		.mem_rd_o(mrd), .mem_pm_o(pm), .mem_addr_o(maddr), .mem_rdata_i(rdata), .bus_req_i(req),
		.bus_grant_o(grant), .arith_status_o(ast), .mode_status_o(mst), .timer_tick_o(tick),
		.result_o(res));
	ext_side px (.mclk_i(mclk_i), .rd_i(mrd), .addr_i(maddr), .want_i(want), .rdata_o(rdata),
		.req_o(req));
	initial forever #5 mclk_i = ~mclk_i;
	task automatic close_out();
		if (err_total == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_total++;
			close_out();
		end
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	function automatic logic [23:0] amr(bit g, bit z, logic [4:0] f, logic [3:0] d, logic [3:0] im);
		return {3'h3, g, 1'b0, z, f, 5'h0, d, im};
	endfunction : amr
	// program memory form: same fields, second generator, prefix 0101
	function automatic logic [23:0] pmw(logic [4:0] f, logic [3:0] d);
		return amr(1'b1, 1'b0, f, d, 4'h0) ^ 24'h200000;
	endfunction : pmw
	function automatic logic [23:0] md(logic [1:0] c, int p);
		return {dsp_pkg::OP_MODE, 16'(c) << p};
	endfunction : md
	function automatic logic [13:0] rev(logic [13:0] x);
		for (int k = 0; k < 14; k++)
			rev[k] = x[13 - k];
	endfunction : rev
	// one idle edge between requests keeps valid from being driven twice in a step
	task automatic issue(input logic [23:0] w);
		@(posedge mclk_i);
		instr <= w;
		vld <= 1'b1;
		@(negedge mclk_i);
		while (rdy !== 1'b1)
			@(negedge mclk_i);
		@(posedge mclk_i);
		vld <= 1'b0;
		@(negedge mclk_i);
	endtask : issue
	task automatic rd(input logic [23:0] w, input logic [13:0] ea);
		issue(w);
		chk("mem_rd", 16'h1, 16'(mrd));
		chk("addr", 16'(ea), 16'(maddr));
		chk("pm", 16'(w[23:20] == dsp_pkg::OP_AMPM || w[23:16] == dsp_pkg::OP_SHPM), 16'(pm));
		@(negedge mclk_i);
	endtask : rd
	task automatic sw(input bit s, input logic [15:0] x);
		@(posedge mclk_i);
		{swr, ssel, dbus} <= {1'b1, s, x};
		@(posedge mclk_i);
		swr <= 1'b0;
		@(negedge mclk_i);
	endtask : sw
	task automatic dl(input bit g, input logic [1:0] k, input logic [1:0] i, input logic [13:0] x);
		@(posedge mclk_i);
		{ld, lg, lk, li, ldd} <= {1'b1, g, k, i, x};
		@(posedge mclk_i);
		ld <= 1'b0;
	endtask : dl
	task automatic wg(input bit x);
		@(posedge mclk_i);
		want <= x;
		repeat (12) begin
			@(negedge mclk_i);
			if (grant === x)
				break;
		end
		chk("grant", 16'(x), 16'(grant));
	endtask : wg
	task automatic ticks(input bit on);
		int n;
		n = 0;
		repeat (300) begin
			@(negedge mclk_i);
			n += int'(tick === 1'b1);
		end
		chk("tick", 16'(on), 16'(n > 0));
	endtask : ticks
	initial begin
		void'($urandom(97));
		repeat (4) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		@(negedge mclk_i);
		chk("mode", 16'(dsp_pkg::MS_RST), 16'(mst));
		for (int i = 0; i < 7; i++) begin
			issue(md(dsp_pkg::MF_ENA, fp[i]));
			chk("mode", 16'h1 << i, 16'(mst));
			issue(md(dsp_pkg::MF_DIS, fp[i]));
			chk("mode", 16'h0, 16'(mst));
		end
		v = 16'($urandom);
		sw(1'b0, v);
		sw(1'b1, v);
		issue(24'h0);
		chk("arith", 16'(v[7:0]), 16'(ast));
		chk("mode", 16'(v[6:0]), 16'(mst));
		sw(1'b1, 16'h0);
		sw(1'b0, 16'h0);
		b = 14'($urandom) & 14'h3f00;
		dl(1'b0, dsp_pkg::LD_MOD, 2'h0, 14'h3);
		dl(1'b0, dsp_pkg::LD_IDX, 2'h0, b);
		px.ram[b] = 16'h7fff;
		px.ram[b + 14'h3] = 16'h0001;
		px.ram[b + 14'h9] = 16'h7fff;
		rd(amr(1'b0, 1'b1, dsp_pkg::FN_PASSY, dsp_pkg::D_XA0, 4'h0), b);
		rd(amr(1'b0, 1'b1, dsp_pkg::FN_PASSY, dsp_pkg::D_YA0, 4'h0), b + 14'h3);
		issue({dsp_pkg::OP_MODIFY, 16'h0});
		rd(amr(1'b0, 1'b0, dsp_pkg::FN_ADD, dsp_pkg::D_YA0, 4'h0), b + 14'h9);
		chk("result", 16'h8000, res);
		chk("arith", 16'h0006, 16'(ast));
		issue(md(dsp_pkg::MF_ENA, dsp_pkg::MF_BANK));
		chk("result", 16'h0, res);
		issue(md(dsp_pkg::MF_ENA, dsp_pkg::MF_CLAMP) | md(dsp_pkg::MF_DIS, dsp_pkg::MF_BANK));
		chk("result", 16'h8000, res);
		rd(amr(1'b0, 1'b0, dsp_pkg::FN_ADD, dsp_pkg::D_XM0, 4'h0), b + 14'hc);
		chk("result", 16'h7fff, res);
		rd(amr(1'b0, 1'b1, dsp_pkg::FN_PASSY, dsp_pkg::D_XM0, 4'h0), b + 14'hf);
		chk("ovf", 16'h0, 16'(ast[dsp_pkg::FL_OVF]));
		issue(md(dsp_pkg::MF_ENA, dsp_pkg::MF_OVH) | md(dsp_pkg::MF_DIS, dsp_pkg::MF_CLAMP));
		chk("mode", 16'h4, 16'(mst));
		rd(amr(1'b0, 1'b0, dsp_pkg::FN_ADD, dsp_pkg::D_XM0, 4'h0), b + 14'h12);
		chk("result", 16'hfffe, res);
		rd(amr(1'b0, 1'b1, dsp_pkg::FN_PASSY, dsp_pkg::D_XM0, 4'h0), b + 14'h15);
		chk("ovf", 16'h1, 16'(ast[dsp_pkg::FL_OVF]));
		sw(1'b0, 16'h0);
		chk("ovf", 16'h0, 16'(ast[dsp_pkg::FL_OVF]));
		a = b + 14'h40;
		dl(1'b0, dsp_pkg::LD_LEN, 2'h1, 14'h5);
		dl(1'b0, dsp_pkg::LD_MOD, 2'h1, 14'h3);
		dl(1'b0, dsp_pkg::LD_IDX, 2'h1, a);
		issue({dsp_pkg::OP_MODIFY, 16'h5});
		issue({dsp_pkg::OP_MODIFY, 16'h5});
		rd(amr(1'b0, 1'b1, dsp_pkg::FN_PASSY, dsp_pkg::D_XM0, 4'h5), a + 14'h1);
		a = 14'($urandom);
		issue(md(dsp_pkg::MF_ENA, dsp_pkg::MF_REV) | md(dsp_pkg::MF_DIS, dsp_pkg::MF_OVH));
		dl(1'b0, dsp_pkg::LD_IDX, 2'h2, a);
		rd(amr(1'b0, 1'b1, dsp_pkg::FN_PASSY, dsp_pkg::D_XM0, 4'h8), rev(a));
		dl(1'b1, dsp_pkg::LD_MOD, 2'h0, 14'h2);
		dl(1'b1, dsp_pkg::LD_IDX, 2'h0, a);
		rd(amr(1'b1, 1'b1, dsp_pkg::FN_PASSY, dsp_pkg::D_XM0, 4'h0), a);
		rd(amr(1'b1, 1'b1, dsp_pkg::FN_PASSY, dsp_pkg::D_XM0, 4'h0), a + 14'h2);
		px.ram[a + 14'h4] = 16'h8003;
		px.ram[a + 14'h6] = 16'h7fff;
		px.ram[a + 14'h8] = 16'h7fff;
		px.ram[a + 14'h10] = 16'h8000;
		rd(pmw(dsp_pkg::FN_PASSY, dsp_pkg::D_XA0), a + 14'h4);
		rd(pmw(dsp_pkg::FN_ABSV, dsp_pkg::D_XM0), a + 14'h6);
		chk("result", 16'h7ffd, res);
		chk("arith", 16'h0010, 16'(ast));
		rd(pmw(dsp_pkg::FN_PASSY, dsp_pkg::D_YM0), a + 14'h8);
		chk("arith", 16'h0010, 16'(ast));
		rd(pmw(dsp_pkg::FN_MUL, 4'h1), a + 14'ha);
		rd(pmw(dsp_pkg::FN_ADD, 4'h1) | 24'h001300, a + 14'hc);
		chk("result", 16'h0002, res);
		rd(pmw(dsp_pkg::FN_MAC, 4'h1), a + 14'he);
		chk("arith", 16'h0050, 16'(ast));
		rd({dsp_pkg::OP_SHPM, 1'b0, dsp_pkg::SH_NORM, 3'h0, dsp_pkg::D_SHIN, 4'h0}, a + 14'h10);
		rd({dsp_pkg::OP_SHDM, 2'h2, dsp_pkg::SH_NORM, 3'h0, 4'h1, 4'h0}, a + 14'h12);
		chk("arith", 16'h00d0, 16'(ast));
		issue(md(dsp_pkg::MF_ENA, dsp_pkg::MF_TIMER) | md(dsp_pkg::MF_DIS, dsp_pkg::MF_REV));
		ticks(1'b1);
		issue(md(dsp_pkg::MF_DIS, dsp_pkg::MF_TIMER));
		ticks(1'b0);
		wg(1'b1);
		chk("ready", 16'h0, 16'(rdy));
		wg(1'b0);
		issue(md(dsp_pkg::MF_ENA, dsp_pkg::MF_GRANT));
		wg(1'b1);
		chk("ready", 16'h1, 16'(rdy));
		@(posedge mclk_i);
		instr <= amr(1'b0, 1'b1, dsp_pkg::FN_PASSY, dsp_pkg::D_XM0, 4'h0);
		@(negedge mclk_i);
		chk("ready", 16'h0, 16'(rdy));
		wg(1'b0);
		chk("ready", 16'h1, 16'(rdy));
		close_out();
	end
endmodule : dsp_mode_and_multifunction_exec_bench

/* verification/ext_side.sv */
module ext_side (
	input  wire logic        mclk_i,
	input  wire logic        rd_i,
	input  wire logic [13:0] addr_i,
	input  wire logic        want_i,
	output logic [15:0]      rdata_o,
	output logic             req_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] ram [16384];
	logic [15:0] junk = 16'h5a5a;
	// outside a read the bus flips each cycle so a stale word never passes
	always @(posedge mclk_i) junk <= ~junk;
	assign rdata_o = rd_i ? ram[addr_i] : junk;
	assign req_o   = want_i;
endmodule : ext_side
